// [src/ebc_map.svh]
`ifndef EBC_MAP_SVH
`define EBC_MAP_SVH

// ==========================================================
// Timing base
// Clock period and bus clock unit, both in ns
`define EBC_CLK_PERIOD_NS 25
`define EBC_UNIT_NS       25
// One bus clock unit in clock cycles (rounded up, never below one)
`define EBC_UNIT_CYCLES   ((`EBC_UNIT_NS + `EBC_CLK_PERIOD_NS - 1) / `EBC_CLK_PERIOD_NS)

// ==========================================================
// Phase length limits, in bus clock units
`define EBC_AB_MIN        6'h01
`define EBC_AB_MAX        6'h05
`define EBC_C_MAX         6'h03
`define EBC_D_MAX         6'h01
`define EBC_E_MIN         6'h01
`define EBC_E_MAX         6'h20
`define EBC_F_MAX         6'h03

// ==========================================================
// Reset values
`define EBC_ADDR_RST      24'h00_0000
`define EBC_DATA_RST      16'h0000
`define EBC_WIN_RST       3'h0

`endif

// [src/ebc_pkg.sv]
package ebc_pkg;

	// ==========================================================
	// Cycle phases, in the fixed order they run
	typedef enum logic [2:0] {
		EBC_IDLE = 3'b000,
		EBC_AB   = 3'b001,
		EBC_C    = 3'b010,
		EBC_D    = 3'b011,
		EBC_E    = 3'b100,
		EBC_F    = 3'b101
	} ebc_state_t;

	// ==========================================================
	// Timing configuration of the selected chip-select window
	typedef struct packed {
		logic       abLong;          // Setup base: 0 = one unit, 1 = two
		logic [1:0] abExtra;         // Extra setup units on window change
		logic [1:0] cLen;            // Command delay units
		logic       dLen;            // Write setup / turnaround units
		logic [4:0] eLen;            // Access units minus one
		logic [1:0] fLen;            // Hold units
		logic       readyEn;         // Access phase may be stretched
		logic       readyAsync;      // Extra synchroniser stage
		logic       readyActiveHigh; // Ready input polarity
		logic       muxMode;         // Shared address/data lines
	} ebc_timing_cfg_t;

	// ==========================================================
	// One bus request
	typedef struct packed {
		logic        write;
		logic [2:0]  window;
		logic [23:0] addr;
		logic [15:0] wdata;
		logic        highByte;
	} ebc_req_t;

	// Phase with its length
	typedef struct packed {
		ebc_state_t state;
		logic [5:0] len;
	} ebc_step_t;

endpackage

// [src/ebc_ready_sync.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ebc_map.svh"

module ebc_ready_sync
	import ebc_pkg::*;
(
	// Clock and control
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic ce,
	// Configuration
	input  wire logic async,
	input  wire logic activeHigh,
	// Pin and result
	input  wire logic readyPin,
	output logic      readyOk
);

	logic directSample;
	logic syncStage1;
	logic syncStage2;
	logic next_directSample;
	logic next_syncStage1;
	logic next_syncStage2;

	// ==========================================================
	// Next values of the samplers
	always_comb begin
		next_directSample = readyPin;
		next_syncStage1   = readyPin;
		next_syncStage2   = syncStage1;
	end

	// Register, frozen while ce is low
	always_ff @(posedge clk) begin
		if (reset) begin
			directSample <= 1'b0;
			syncStage1   <= 1'b0;
			syncStage2   <= 1'b0;
		end else if (ce) begin
			directSample <= next_directSample;
			syncStage1   <= next_syncStage1;
			syncStage2   <= next_syncStage2;
		end
	end

	// Async path pays one more stage
	assign readyOk = (async ? syncStage2 : directSample) == activeHigh;

	a_async_stage: assert property (@(posedge clk) disable iff (reset)
		(ce && async && $past(ce) && $past(ce, 2)) |->
			(readyOk == ($past(readyPin, 2) == activeHigh)))
		else $error("async ready does not pass two stages");

endmodule

`default_nettype wire

// [src/ebc_phase_seq.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ebc_map.svh"

module ebc_phase_seq
	import ebc_pkg::*;
(
	// Clock and control
	input  wire logic            clk,
	input  wire logic            reset,
	input  wire logic            ce,
	// Request side
	input  wire logic            reqValid,
	input  wire ebc_req_t        req,
	input  wire ebc_timing_cfg_t cfg,
	output logic                 reqReady,
	output logic                 donePulse,
	output logic [15:0]          readData,
	// Bus pins
	input  wire logic            readyPin,
	output logic                 chipSelN,
	output logic                 addrLatchEn,
	output logic                 readStrobeN,
	output logic                 writeStrobeN,
	output logic                 high_byte_enable_n,
	output logic [23:0]          address_lines,
	output logic [15:0]          data_lines_out,
	output logic                 data_lines_oe,
	input  wire logic [15:0]     data_lines_in,
	output logic [15:0]          shared_addr_data_lines_out,
	output logic                 shared_addr_data_lines_oe,
	input  wire logic [15:0]     shared_addr_data_lines_in
);

	// ==========================================================
	// State
	ebc_state_t      state;
	ebc_state_t      next_state;
	logic [5:0]      cnt;
	logic [5:0]      next_cnt;
	ebc_req_t        cur;
	ebc_req_t        next_cur;
	ebc_timing_cfg_t curCfg;
	ebc_timing_cfg_t next_curCfg;
	logic            winChg;
	logic            next_winChg;
	logic [2:0]      lastWin;
	logic [2:0]      next_lastWin;
	logic            readyOk;
	ebc_step_t       step;
	logic            leaving;

	// Ready input conditioning
	ebc_ready_sync u_ready (
		.clk        (clk),
		.reset      (reset),
		.ce         (ce),
		.async      (curCfg.readyAsync),
		.activeHigh (curCfg.readyActiveHigh),
		.readyPin   (readyPin),
		.readyOk    (readyOk)
	);

	// ==========================================================
	// Length of a phase in bus clock units
	function automatic logic [5:0] phaseLen(ebc_state_t p, ebc_timing_cfg_t c, logic chg);
		logic [5:0] len;
		len = 6'h00;
		case (p)
			EBC_AB: len = `EBC_AB_MIN + {5'h00, c.abLong}
				+ (chg ? {4'h0, c.abExtra} : 6'h00);
			EBC_C:  len = {4'h0, c.cLen};
			EBC_D:  len = {5'h00, c.dLen};
			EBC_E:  len = `EBC_E_MIN + {1'b0, c.eLen};
			EBC_F:  len = {4'h0, c.fLen};
			default: len = 6'h00;
		endcase
		return len;
	endfunction

	// First phase from p onward that has a nonzero length
	function automatic ebc_step_t enterFrom(ebc_state_t p, ebc_timing_cfg_t c, logic chg);
		ebc_step_t s;
		s.state = p;
		s.len   = phaseLen(p, c, chg);
		for (int i = 0; i < 4; i++) begin
			if (s.state != EBC_IDLE && s.len == 6'h00) begin
				s.state = (s.state == EBC_F) ? EBC_IDLE
					: ebc_state_t'(3'(s.state) + 3'h1);
				s.len   = phaseLen(s.state, c, chg);
			end
		end
		return s;
	endfunction

	// ==========================================================
	// Phase sequencer next state
	always_comb begin
		next_state   = state;
		next_cnt     = cnt;
		next_cur     = cur;
		next_curCfg  = curCfg;
		next_winChg  = winChg;
		next_lastWin = lastWin;
		step         = '0;
		leaving      = 1'b0;
		case (state)
			EBC_IDLE: begin
				if (reqValid) begin
					next_cur     = req;
					next_curCfg  = cfg;
					next_winChg  = (req.window != lastWin);
					next_lastWin = req.window;
					next_state   = EBC_AB;
					next_cnt     = phaseLen(EBC_AB, cfg, req.window != lastWin);
				end
			end
			EBC_AB, EBC_C, EBC_D, EBC_E, EBC_F: begin
				if (cnt > 6'h01) begin
					next_cnt = cnt - 6'h01;
				end else if (state == EBC_E && curCfg.readyEn && !readyOk) begin
					next_cnt = 6'h01;
				end else begin
					leaving    = 1'b1;
					step       = (state == EBC_F) ? '0
						: enterFrom(ebc_state_t'(3'(state) + 3'h1), curCfg, winChg);
					next_state = step.state;
					next_cnt   = step.len;
				end
			end
			default: begin
				next_state = EBC_IDLE;
				next_cnt   = 6'h00;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state   <= EBC_IDLE;
			cnt     <= 6'h00;
			cur     <= '0;
			curCfg  <= '0;
			winChg  <= 1'b0;
			lastWin <= `EBC_WIN_RST;
		end else if (ce) begin
			state   <= next_state;
			cnt     <= next_cnt;
			cur     <= next_cur;
			curCfg  <= next_curCfg;
			winChg  <= next_winChg;
			lastWin <= next_lastWin;
		end
	end

	// ==========================================================
	// Pin outputs, decoded from the next phase so they come from flops
	logic        next_chipSelN;
	logic        next_addrLatchEn;
	logic        next_readStrobeN;
	logic        next_writeStrobeN;
	logic        next_highByteN;
	logic [23:0] next_address;
	logic [15:0] next_dataOut;
	logic        next_dataOe;
	logic [15:0] next_sharedOut;
	logic        next_sharedOe;
	logic        next_reqReady;
	logic        next_donePulse;
	logic [15:0] next_readData;
	logic        active;
	ebc_req_t    nr;
	ebc_timing_cfg_t nc;

	always_comb begin
		nr                = next_cur;
		nc                = next_curCfg;
		active            = (next_state != EBC_IDLE);
		next_chipSelN     = !active;
		next_addrLatchEn  = (next_state == EBC_AB) && nc.muxMode;
		next_readStrobeN  = !((next_state == EBC_E) && !nr.write);
		next_writeStrobeN = !((next_state == EBC_E) && nr.write);
		next_highByteN    = !(active && nr.highByte);
		next_address      = active ? nr.addr : address_lines; // Held through hold phase
		next_dataOut      = nr.wdata;
		next_dataOe       = active && !nc.muxMode && nr.write && (next_state != EBC_AB);
		next_sharedOut    = (next_state == EBC_AB) ? nr.addr[15:0] : nr.wdata;
		next_sharedOe     = nc.muxMode && ((next_state == EBC_AB)
			|| (active && nr.write));
		next_reqReady     = (next_state == EBC_IDLE);
		next_donePulse    = leaving && (state == EBC_F || next_state == EBC_IDLE);
		next_readData     = readData;
		// Latch on the edge that raises the read strobe
		if (state == EBC_E && leaving && !cur.write) begin
			next_readData = curCfg.muxMode ? shared_addr_data_lines_in
				: data_lines_in;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			chipSelN                   <= 1'b1;
			addrLatchEn                <= 1'b0;
			readStrobeN                <= 1'b1;
			writeStrobeN               <= 1'b1;
			high_byte_enable_n         <= 1'b1;
			address_lines              <= `EBC_ADDR_RST;
			data_lines_out             <= `EBC_DATA_RST;
			data_lines_oe              <= 1'b0;
			shared_addr_data_lines_out <= `EBC_DATA_RST;
			shared_addr_data_lines_oe  <= 1'b0;
			reqReady                   <= 1'b1;
			donePulse                  <= 1'b0;
			readData                   <= `EBC_DATA_RST;
		end else if (ce) begin
			chipSelN                   <= next_chipSelN;
			addrLatchEn                <= next_addrLatchEn;
			readStrobeN                <= next_readStrobeN;
			writeStrobeN               <= next_writeStrobeN;
			high_byte_enable_n         <= next_highByteN;
			address_lines              <= next_address;
			data_lines_out             <= next_dataOut;
			data_lines_oe              <= next_dataOe;
			shared_addr_data_lines_out <= next_sharedOut;
			shared_addr_data_lines_oe  <= next_sharedOe;
			reqReady                   <= next_reqReady;
			donePulse                  <= next_donePulse;
			readData                   <= next_readData;
		end
	end

	// ==========================================================
	// Checks
	a_ab_setup_len: assert property (@(posedge clk) disable iff (reset)
		(ce && state == EBC_IDLE && reqValid && req.window == lastWin) |=>
			(state == EBC_AB && cnt == `EBC_AB_MIN + {5'h00, cfg.abLong}))
		else $error("setup length wrong without window change");

	a_ab_window_ext: assert property (@(posedge clk) disable iff (reset)
		(state == EBC_AB) |-> (cnt >= `EBC_AB_MIN && cnt <= `EBC_AB_MAX))
		else $error("setup length outside one to five");

	a_cd_bounds: assert property (@(posedge clk) disable iff (reset)
		(state == EBC_C && cnt <= `EBC_C_MAX && cnt != 6'h00)
			or (state == EBC_D && cnt == `EBC_D_MAX)
			or (state != EBC_C && state != EBC_D))
		else $error("command delay or write setup out of range");

	a_access_len: assert property (@(posedge clk) disable iff (reset)
		(ce && state != EBC_E && next_state == EBC_E) |=>
			(cnt == `EBC_E_MIN + {1'b0, curCfg.eLen} && cnt <= `EBC_E_MAX))
		else $error("access phase length wrong");

	a_hold_len: assert property (@(posedge clk) disable iff (reset)
		(state == EBC_F) |-> (cnt <= `EBC_F_MAX && !chipSelN && readStrobeN))
		else $error("hold phase length or strobe wrong");

	a_read_capture: assert property (@(posedge clk) disable iff (reset)
		(ce && state == EBC_E && leaving && !cur.write && !curCfg.muxMode) |=>
			(readData == $past(data_lines_in) && readStrobeN))
		else $error("read data not captured at strobe end");

	a_strobe_end: assert property (@(posedge clk) disable iff (reset)
		($rose(readStrobeN) && !$past(cur.write)) |-> $past(state) == EBC_E)
		else $error("read strobe rose outside access end");

	a_phase_order: assert property (@(posedge clk) disable iff (reset)
		(state != EBC_IDLE && state != $past(state) && !$past(reset)) |->
			(3'(state) > 3'($past(state))))
		else $error("phases out of order");

	a_ready_wait: assert property (@(posedge clk) disable iff (reset)
		(ce && state == EBC_E && cnt == 6'h01 && curCfg.readyEn && !readyOk) |=>
			(state == EBC_E && cnt == 6'h01))
		else $error("wait state not inserted");

	a_mux_address: assert property (@(posedge clk) disable iff (reset)
		(state == EBC_AB && curCfg.muxMode) |->
			(shared_addr_data_lines_oe && shared_addr_data_lines_out == cur.addr[15:0]))
		else $error("address not driven on shared lines");

endmodule

`default_nettype wire

// [verif/ebc_ext_mem.sv]
`timescale 1ns/1ps
`default_nettype none

module ebc_ext_mem
	import ebc_pkg::*;
(
	// Clock and bus pins
	input  wire logic        clk,
	input  wire logic        addrLatchEn,
	input  wire logic        readStrobeN,
	input  wire logic        writeStrobeN,
	input  wire logic [23:0] address_lines,
	input  wire logic [15:0] wrData,
	// Mode and ready control
	input  wire logic        muxMode,
	input  wire logic        activeHigh,
	input  wire logic [3:0]  readyDelay,
	output logic             readyPin,
	output logic [15:0]      rdData
);
	// ==========================================================
	// Storage and address select
	logic [15:0] mem [0:255];
	logic [15:0] junk = 16'h0000;
	logic [7:0]  latchAddr = 8'h00;
	logic [3:0]  lowCount = 4'h0;
	logic [7:0]  selAddr;
	initial for (int i = 0; i < 256; i++) mem[i] = 16'h3c3c ^ (16'h0101 * i);
	assign selAddr = muxMode ? latchAddr : address_lines[7:0];

	// Latch, write, strobe count and idle pattern
	always @(posedge clk) begin
		if (addrLatchEn) latchAddr <= wrData[7:0];
		if (!writeStrobeN) mem[selAddr] <= wrData;
		lowCount <= (readStrobeN && writeStrobeN) ? 4'h0 : lowCount + 4'h1;
		junk <= junk + 16'h1357;
	end

	// Data only while strobed, changing pattern otherwise
	assign rdData = readStrobeN ? junk : mem[selAddr];
	// Ready active once strobe low long enough
	assign readyPin = ((!readStrobeN || !writeStrobeN) && lowCount >= readyDelay)
		? activeHigh : !activeHigh;
endmodule

`default_nettype wire

// [verif/external_bus_cycle_phases_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module external_bus_cycle_phases_bench
	import ebc_pkg::*;
;
	// ==========================================================
	// Signals
	logic clk = 1'b0, reset = 1'b1, ce = 1'b1, reqValid = 1'b0;
	ebc_req_t req = '0;
	ebc_timing_cfg_t cfg = '0;
	logic reqReady, donePulse, readyPin, chipSelN, addrLatchEn, readStrobeN, writeStrobeN;
	logic high_byte_enable_n, data_lines_oe, shared_addr_data_lines_oe;
	logic [15:0] readData, data_lines_out, shared_addr_data_lines_out, rdData, busWr;
	logic [23:0] address_lines;
	logic [3:0] readyDelay = 4'h0;
	logic [15:0] shadow [0:255];
	logic [2:0] lastWin = 3'h0;
	int mismatches = 0, totalChecks = 0;
	logic busOe;

	always #12.5 clk = ~clk;
	assign busWr = cfg.muxMode ? shared_addr_data_lines_out : data_lines_out;
	assign busOe = cfg.muxMode ? shared_addr_data_lines_oe : data_lines_oe;

	// ==========================================================
	// Design and far side
	ebc_phase_seq uut (.clk(clk), .reset(reset), .ce(ce), .reqValid(reqValid), .req(req),
		.cfg(cfg), .reqReady(reqReady), .donePulse(donePulse), .readData(readData),
		.readyPin(readyPin), .chipSelN(chipSelN), .addrLatchEn(addrLatchEn),
		.readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN),
		.high_byte_enable_n(high_byte_enable_n), .address_lines(address_lines),
		.data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
		.data_lines_in(data_lines_oe ? data_lines_out : rdData),
		.shared_addr_data_lines_out(shared_addr_data_lines_out),
		.shared_addr_data_lines_oe(shared_addr_data_lines_oe),
		.shared_addr_data_lines_in(shared_addr_data_lines_oe ? busWr : rdData));
	ebc_ext_mem mem (.clk(clk), .addrLatchEn(addrLatchEn), .readStrobeN(readStrobeN),
		.writeStrobeN(writeStrobeN), .address_lines(address_lines), .wrData(busWr),
		.muxMode(cfg.muxMode), .activeHigh(cfg.readyActiveHigh), .readyDelay(readyDelay),
		.readyPin(readyPin), .rdData(rdData));

	// ==========================================================
	// Shared tasks
	task automatic check(input logic ok, input string msg);
		totalChecks++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask

	task automatic printVerdict;
		if (mismatches == 0 && totalChecks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic set_cfg(input logic ab, input logic [1:0] c, input logic d,
		input logic [4:0] e, input logic [1:0] f, input logic mux);
		cfg = '0;
		{cfg.abLong, cfg.cLen, cfg.dLen, cfg.eLen, cfg.fLen, cfg.muxMode} = {ab, c, d, e, f, mux};
	endtask

	// One bus cycle, measured by select, latch and strobe counts
	task automatic run_cycle(input logic wr, input logic [2:0] win, input logic [7:0] a,
		input int gap, output int sLen);
		int n, csLow, ale, ab;
		logic [15:0] wd;
		begin
			n = 0; csLow = 0; ale = 0; sLen = 0;
			wd = {a, ~a};
			ab = 1 + cfg.abLong + ((win != lastWin) ? cfg.abExtra : 0);
			lastWin = win;
			@(negedge clk);
			req = '{wr, win, {16'h0000, a}, wd, wr};
			reqValid = 1'b1;
			@(negedge clk);
			while (donePulse !== 1'b1 && n < 200) begin
				n++;
				reqValid = (n == 1); // Refused while busy
				if (n == 2 && gap > 0) ce = 1'b0;
				if (n == 2 + gap) ce = 1'b1;
				if (chipSelN === 1'b0) csLow++;
				if (addrLatchEn === 1'b1) begin
					ale++;
					check(shared_addr_data_lines_out === {8'h00, a}, "mux address");
				end
				if ((wr ? writeStrobeN : readStrobeN) === 1'b0) begin
					sLen++;
					if (wr) check(busOe === 1'b1 && busWr === wd, "write data");
					else check(busOe === 1'b0, "bus not released");
				end
				check(reqReady === chipSelN && address_lines === {16'h0000, a}, "busy");
				check(high_byte_enable_n === (chipSelN | ~wr), "byte enable");
				@(negedge clk);
			end
			check(chipSelN === 1'b1 && reqReady === 1'b1, "idle at done");
			if (!cfg.readyEn) check(sLen == cfg.eLen + 1, "access length");
			check(n == ab + cfg.cLen + cfg.dLen + sLen + cfg.fLen + gap, "cycle length");
			check(csLow == n, "select length");
			check(ale == (cfg.muxMode ? ab + gap : 0), "latch length");
			if (wr) shadow[a] = wd;
			else check(readData === shadow[a], "read data");
			@(negedge clk);
			check(donePulse === 1'b0, "done width");
		end
	endtask

	// ==========================================================
	// Scenarios
	task automatic s_reset;
		check(chipSelN === 1'b1 && reqReady === 1'b1 && donePulse === 1'b0, "reset state");
		check(readStrobeN === 1'b1 && writeStrobeN === 1'b1 && readData === 16'h0000, "reset");
	endtask

	task automatic s_phases;
		logic [11:0] tbl [0:5] = '{12'h000, 12'h000, 12'hfff, 12'h5a4, 12'h8c2, 12'h3e1};
		int l;
		for (int i = 0; i < 6; i++) begin
			set_cfg(tbl[i][0], tbl[i][2:1], tbl[i][3], tbl[i][8:4], tbl[i][10:9], tbl[i][11]);
			if (i == 1) cfg.eLen = 5'h1f;
			run_cycle(1'b1, 3'h0, 8'h10 + 8'(i), 0, l);
			run_cycle(1'b0, 3'h0, 8'h10 + 8'(i), 0, l);
		end
	endtask

	task automatic s_window;
		int l;
		set_cfg(1'b1, 2'h0, 1'b0, 5'h00, 2'h0, 1'b1);
		cfg.abExtra = 2'h3;
		run_cycle(1'b0, 3'h5, 8'h21, 0, l);
		run_cycle(1'b0, 3'h5, 8'h22, 0, l);
		cfg.abExtra = 2'h1;
		run_cycle(1'b1, 3'h2, 8'h23, 0, l);
	endtask

	task automatic s_ready;
		int syncLen, asyncLen, slowLen;
		set_cfg(1'b0, 2'h1, 1'b0, 5'h00, 2'h1, 1'b0);
		cfg.readyEn = 1'b1;
		cfg.readyActiveHigh = 1'b1;
		run_cycle(1'b0, 3'h0, 8'h30, 0, syncLen);
		cfg.readyAsync = 1'b1;
		run_cycle(1'b0, 3'h0, 8'h30, 0, asyncLen);
		check(asyncLen >= syncLen + 1, "async wait");
		cfg.readyAsync = 1'b0;
		cfg.readyActiveHigh = 1'b0;
		readyDelay = 4'h4;
		run_cycle(1'b1, 3'h0, 8'h31, 0, slowLen);
		check(slowLen >= 5 && slowLen <= 8, "ready waits");
		readyDelay = 4'h0;
	endtask

	task automatic s_freeze;
		int l;
		set_cfg(1'b1, 2'h2, 1'b1, 5'h02, 2'h3, 1'b1);
		cfg.abExtra = 2'h2;
		run_cycle(1'b1, 3'h7, 8'h40, 3, l);
		run_cycle(1'b0, 3'h1, 8'h40, 2, l);
	endtask

	// Reset in mid cycle: pins drop back, window memory clears, no write lands
	task automatic s_midreset;
		int l;
		set_cfg(1'b1, 2'h3, 1'b1, 5'h07, 2'h3, 1'b0);
		cfg.abExtra = 2'h3;
		@(negedge clk);
		req = '{1'b1, 3'h6, 24'h00_0050, 16'hbeef, 1'b1};
		reqValid = 1'b1;
		@(negedge clk);
		reqValid = 1'b0;
		reset = 1'b1;
		@(negedge clk);
		reset = 1'b0;
		check(chipSelN === 1'b1 && writeStrobeN === 1'b1 && reqReady === 1'b1, "mid reset");
		check(address_lines === 24'h00_0000 && data_lines_oe === 1'b0, "mid reset pins");
		lastWin = 3'h0;
		run_cycle(1'b0, 3'h0, 8'h50, 0, l);
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		for (int i = 0; i < 256; i++) shadow[i] = 16'h3c3c ^ (16'h0101 * i);
		repeat (16) @(negedge clk);
		reset = 1'b0;
		s_reset();
		s_phases();
		s_window();
		s_ready();
		s_freeze();
		s_midreset();
		printVerdict();
	end

	initial begin
		#(25 * 5000);
		mismatches++;
		printVerdict();
	end
endmodule

`default_nettype wire
